/* aor_nv_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Far-side memory responder
// ----------------------------------------
module aor_nv_model
  import aor_pkg::*;
#(
  parameter int DELAY = 20,
  parameter logic [7:0] READ_BYTE = 8'h6B
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic nvStart,
  input wire logic [1:0] nvCmd,
  input wire logic [7:0] nvWriteByte,
  output logic nvDone,
  output logic nvFail,
  output logic [7:0] nvReadByte
);
  int cnt;
  assign nvFail = 1'b0;
  // Data is only valid in the done cycle; otherwise show the inverse
  assign nvReadByte = nvDone ? READ_BYTE : ~READ_BYTE;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt <= 0;
      nvDone <= 1'b0;
    end
    else
    begin
      nvDone <= (cnt == 1);
      if (nvStart && nvCmd[1])
        cnt <= DELAY;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule

/* aor_pkg.sv */
package aor_pkg;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [6:0] OFF_MB_IN = 7'h0C;
  localparam logic [6:0] OFF_MB_OUT = 7'h1C;
  localparam logic [6:0] OFF_PT_ADDR = 7'h28;
  localparam logic [6:0] OFF_PT_DATA = 7'h2C;
  localparam logic [6:0] OFF_MB_FILL = 7'h34;
  localparam logic [6:0] OFF_INT = 7'h38;
  localparam logic [6:0] OFF_RST = 7'h3C;
  localparam logic [6:0] OFF_PT_CFG = 7'h60;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FILL_IN_LSB = 12;
  localparam int FILL_OUT_LSB = 28;
  localparam int INT_ANY_BIT = 23;
  localparam int INT_SELFTEST_BIT = 20;
  localparam int INT_OUT_BIT = 17;
  localparam int INT_IN_BIT = 16;
  localparam int INT_OUT_EN_BIT = 12;
  localparam int INT_OUT_SEL_LSB = 8;
  localparam int INT_IN_EN_BIT = 4;
  localparam int INT_IN_SEL_LSB = 0;
  localparam int RST_NV_BUSY_BIT = 31;
  localparam int RST_NV_CMD_LSB = 29;
  localparam int RST_NV_FAIL_BIT = 28;
  localparam int RST_MB_FLAGS_BIT = 27;
  localparam int RST_RDFIFO_BIT = 25;
  localparam int RST_NV_PORT_LSB = 16;
  localparam int RST_BIST_LSB = 12;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] INT_FIXED_ONES = 32'h00000C0C;
  localparam logic [31:0] PT_CFG_RESET = 32'h80808080;
  localparam logic [31:0] RST_RESET = 32'h00000000;

  // nvRAM command codes in bits 30:29 (with 31 set)
  localparam logic [1:0] NV_LOAD_LO = 2'h0;
  localparam logic [1:0] NV_LOAD_HI = 2'h1;
  localparam logic [1:0] NV_WRITE = 2'h2;
  localparam logic [1:0] NV_READ = 2'h3;

  typedef enum {NV_IDLE, NV_WAIT} aor_nv_e;

  // Local bus request
  typedef struct packed {
    logic selectN;
    logic rdN;
    logic wrN;
    logic [3:0] beN;
    logic [6:0] addr;
    logic [31:0] wdata;
  } aor_bus_s;

  // Events from the host side of the bridge
  typedef struct packed {
    logic [3:0] inWriteBe;
    logic [31:0] inWriteData;
    logic [3:0] outReadBe;
    logic selfTestStart;
    logic ptClaim;
    logic [31:0] ptAddr;
    logic ptXferDone;
    logic [31:0] ptWriteData;
  } aor_host_s;

endpackage

/* aor_registers.sv */
`timescale 1ns/1ns
// What this block does
// R01: Eight dword registers reached by select, byte enables and read or write strobe.
// R02: All register accesses are sampled and driven on the local clock.
// R03: Local logic must not touch offsets outside the map; such reads return zero.
// R04: Incoming mailbox at 0Ch is read only, any access width.
// R05: Local read of incoming mailbox raises host interrupt when host enabled it.
// R06: Outgoing mailbox at 1Ch is writable by byte; writes raise enabled host interrupt.
// R07: Top byte of outgoing mailbox also loads from external mailbox port.
// R08: Reading outgoing mailbox changes no interrupt or fill status.
// R09: Pass-thru address captures the cycle address on a region claim.
// R10: Pass-thru address advances by one dword after each data transfer.
// R11: Passive mode waits until local reads (host write) or writes (host read) data.
// R12: Fill status shows incoming in 15:12, outgoing in 31:28, resets to zero.
// R13: Fill bit sets when source writes a byte, clears when destination reads it.
// R14: Outgoing fill bits 31..28 map to outgoing bytes 3..0.
// R15: Incoming fill bits 15..12 map to incoming bytes 3..0.
// R16: Interrupt bit 23 is OR of bits 20, 17 and 16.
// R17: Bit 20 sets on host self-test start, cleared by writing one.
// R18: Local logic returns self-test codes through the reset control register.
// R19: Bit 17 sets when host reads selected outgoing byte; write one clears.
// R20: Bit 16 sets when host writes selected incoming byte; write one clears.
// R21: Bit 12 enables outgoing interrupt; field 9:8 picks byte 0..3.
// R22: Bit 4 enables incoming interrupt; field 1:0 picks byte, 00 byte0, 11 byte3.
// R23: Incoming select codes 01 and 10 pick bytes 1 and 2.
// R24: Reset control at 3Ch resets to zero; flag reset, FIFO reset, nvRAM access.
// R25: Writing one to bit 27 pulses clear of all mailbox fill flags; reads zero.
// R26: Writing one to bit 25 pulses read FIFO reset; use with no pass-thru active.
// R27: Bits 15:12 drive self-test register bits 3:0 directly.
// R28: nvRAM via bits 31:29 and port 23:16; bit 31 reads busy.
module aor_registers
  import aor_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input aor_bus_s bus,
  output logic [31:0] rdata,
  input aor_host_s host,
  input wire logic extMbWrite,
  input wire logic [7:0] extMbData,
  input wire logic hostInEnable,
  input wire logic hostOutEnable,
  output logic hostInReadEvent,
  output logic hostOutWriteEvent,
  output logic [31:0] mbOut,
  output logic [3:0] outFill,
  output logic [31:0] ptReadData,
  output logic ptWait,
  input wire logic ptPassive,
  input wire logic ptHostRead,
  output logic rdFifoReset,
  output logic [3:0] bistCode,
  output logic intPending,
  output logic [31:0] ptCfg,
  output logic nvStart,
  output logic [1:0] nvCmd,
  output logic [7:0] nvWriteByte,
  input wire logic nvDone,
  input wire logic nvFail,
  input wire logic [7:0] nvReadByte
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic rd;
  logic wr;
  logic [3:0] be;
  logic [31:0] mbIn_reg;
  logic [3:0] inFill_reg;
  logic [3:0] outFill_reg;
  logic [31:0] mbOut_reg;
  logic [31:0] ptAddr_reg;
  logic [31:0] ptData_reg;
  logic ptHeld_reg;
  logic [2:0] intFlags_reg;
  logic outEn_reg;
  logic inEn_reg;
  logic [1:0] outSel_reg;
  logic [1:0] inSel_reg;
  logic [3:0] bist_reg;
  logic [7:0] nvPort_reg;
  logic nvFail_reg;
  logic [31:0] ptCfg_reg;
  logic mbClear;
  logic [31:0] intView;
  logic [31:0] rstView;
  aor_nv_e nvState;

  assign acc = !bus.selectN;                                      // [R01]
  assign rd = acc && !bus.rdN;
  assign wr = acc && !bus.wrN;
  assign be = ~bus.beN;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] e);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (e[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // ----------------------------------------
  // Mailboxes
  // ----------------------------------------
  assign mbClear = wr && bus.addr == OFF_RST && be[3] && bus.wdata[RST_MB_FLAGS_BIT]; // [R25]

  always_ff @(posedge clock)                                       // [R02]
  begin
    mbIn_reg <= merge(mbIn_reg, host.inWriteData, host.inWriteBe); // [R04]
    if (wr && bus.addr == OFF_MB_OUT)
      mbOut_reg <= merge(mbOut_reg, bus.wdata, be);                // [R06]
    if (extMbWrite)
      mbOut_reg[31:24] <= extMbData;                               // [R07]
  end

  // Set wins over a read clear, so a byte landing with a read is never lost
  always_ff @(posedge clock)
  begin
    if (sys_rst || mbClear)
    begin
      inFill_reg <= 4'h0;                                          // [R12]
      outFill_reg <= 4'h0;
    end
    else
    begin
      inFill_reg <= (inFill_reg & ~((rd && bus.addr == OFF_MB_IN) ? be : 4'h0))
                    | host.inWriteBe;                              // [R13] [R15]
      outFill_reg <= (outFill_reg & ~host.outReadBe)
                     | ((wr && bus.addr == OFF_MB_OUT) ? be : 4'h0)
                     | {extMbWrite, 3'h0};                         // [R14] [R08]
    end
  end

  assign hostInReadEvent = hostInEnable && rd && bus.addr == OFF_MB_IN;   // [R05]
  assign hostOutWriteEvent = hostOutEnable && wr && bus.addr == OFF_MB_OUT; // [R06]
  assign mbOut = mbOut_reg;
  assign outFill = outFill_reg;

  // ----------------------------------------
  // Pass-thru
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (host.ptClaim)
      ptAddr_reg <= host.ptAddr;                                   // [R09]
    else if (host.ptXferDone)
      ptAddr_reg <= ptAddr_reg + 32'h00000004;                     // [R10]
    if (host.ptClaim && !ptHostRead)
      ptData_reg <= host.ptWriteData;
    else if (wr && bus.addr == OFF_PT_DATA)
      ptData_reg <= merge(ptData_reg, bus.wdata, be);
  end

  // Host is held off until the local side services the data port
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ptHeld_reg <= 1'b0;
    else if (host.ptClaim && ptPassive)
      ptHeld_reg <= 1'b1;
    else if ((rd && !ptHostRead || wr && ptHostRead) && bus.addr == OFF_PT_DATA)
      ptHeld_reg <= 1'b0;                                          // [R11]
  end

  assign ptWait = ptHeld_reg;
  assign ptReadData = ptData_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ptCfg_reg <= PT_CFG_RESET;
    else if (wr && bus.addr == OFF_PT_CFG)
      ptCfg_reg <= merge(ptCfg_reg, bus.wdata, be);
  end
  assign ptCfg = ptCfg_reg;

  // ----------------------------------------
  // Interrupt control and status
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      outEn_reg <= 1'b0;
      inEn_reg <= 1'b0;
      outSel_reg <= 2'h0;
      inSel_reg <= 2'h0;
    end
    else if (wr && bus.addr == OFF_INT)
    begin
      if (be[1])
      begin
        outEn_reg <= bus.wdata[INT_OUT_EN_BIT];                    // [R21]
        outSel_reg <= bus.wdata[INT_OUT_SEL_LSB +: 2];
      end
      if (be[0])
      begin
        inEn_reg <= bus.wdata[INT_IN_EN_BIT];                      // [R22]
        inSel_reg <= bus.wdata[INT_IN_SEL_LSB +: 2];               // [R23]
      end
    end
  end

  // Write-one-to-clear, with a fresh event taking priority
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      intFlags_reg <= 3'h0;
    else
    begin
      intFlags_reg[2] <= (intFlags_reg[2] && !(wr && bus.addr == OFF_INT && be[2]
                         && bus.wdata[INT_SELFTEST_BIT])) || host.selfTestStart; // [R17]
      intFlags_reg[1] <= (intFlags_reg[1] && !(wr && bus.addr == OFF_INT && be[2]
                         && bus.wdata[INT_OUT_BIT]))
                         || (outEn_reg && host.outReadBe[outSel_reg]);          // [R19]
      intFlags_reg[0] <= (intFlags_reg[0] && !(wr && bus.addr == OFF_INT && be[2]
                         && bus.wdata[INT_IN_BIT]))
                         || (inEn_reg && host.inWriteBe[inSel_reg]);            // [R20]
    end
  end

  assign intPending = |intFlags_reg;                               // [R16]

  always_comb
  begin
    intView = INT_FIXED_ONES;
    intView[INT_ANY_BIT] = intPending;
    intView[INT_SELFTEST_BIT] = intFlags_reg[2];
    intView[INT_OUT_BIT] = intFlags_reg[1];
    intView[INT_IN_BIT] = intFlags_reg[0];
    intView[INT_OUT_EN_BIT] = outEn_reg;
    intView[INT_OUT_SEL_LSB +: 2] = outSel_reg;
    intView[INT_IN_EN_BIT] = inEn_reg;
    intView[INT_IN_SEL_LSB +: 2] = inSel_reg;
  end

  // ----------------------------------------
  // Reset control and nvRAM
  // ----------------------------------------
  assign rdFifoReset = wr && bus.addr == OFF_RST && be[3] && bus.wdata[RST_RDFIFO_BIT]; // [R26]

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bist_reg <= RST_RESET[RST_BIST_LSB +: 4];                    // [R24]
    else if (wr && bus.addr == OFF_RST && be[1])
      bist_reg <= bus.wdata[RST_BIST_LSB +: 4];                    // [R18]
  end
  assign bistCode = bist_reg;                                      // [R27]

  // One access at a time; writes while busy are ignored
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      nvState <= NV_IDLE;
      nvPort_reg <= RST_RESET[RST_NV_PORT_LSB +: 8];
      nvFail_reg <= 1'b0;
      nvStart <= 1'b0;
      nvCmd <= 2'h0;
    end
    else
    begin
      nvStart <= 1'b0;
      case (nvState)
        NV_IDLE:
        begin
          if (wr && bus.addr == OFF_RST && be[3] && bus.wdata[RST_NV_BUSY_BIT])
          begin
            nvCmd <= bus.wdata[RST_NV_CMD_LSB +: 2];               // [R28]
            if (be[2])
              nvPort_reg <= bus.wdata[RST_NV_PORT_LSB +: 8];
            if (bus.wdata[RST_NV_CMD_LSB +: 2] == NV_WRITE
                || bus.wdata[RST_NV_CMD_LSB +: 2] == NV_READ)
            begin
              nvFail_reg <= 1'b0;
              nvStart <= 1'b1;
              nvState <= NV_WAIT;
            end
          end
          else if (wr && bus.addr == OFF_RST && be[2])
            nvPort_reg <= bus.wdata[RST_NV_PORT_LSB +: 8];
        end
        NV_WAIT:
        begin
          if (nvDone)
          begin
            nvFail_reg <= nvFail;
            if (nvCmd == NV_READ)
              nvPort_reg <= nvReadByte;
            nvState <= NV_IDLE;
          end
        end
        default:
          nvState <= NV_IDLE;
      endcase
    end
  end
  assign nvWriteByte = nvPort_reg;

  always_comb
  begin
    rstView = 32'h00000000;
    rstView[RST_NV_BUSY_BIT] = nvState == NV_WAIT;                 // [R28]
    rstView[RST_NV_CMD_LSB +: 2] = nvCmd;
    rstView[RST_NV_FAIL_BIT] = nvFail_reg;
    rstView[RST_NV_PORT_LSB +: 8] = nvPort_reg;
    rstView[RST_BIST_LSB +: 4] = bist_reg;
  end

  // ----------------------------------------
  // Read data, registered
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      case (bus.addr)
        OFF_MB_IN: rdata <= mbIn_reg;
        OFF_MB_OUT: rdata <= mbOut_reg;
        OFF_PT_ADDR: rdata <= ptAddr_reg;
        OFF_PT_DATA: rdata <= ptData_reg;
        OFF_MB_FILL: rdata <= {outFill_reg, 12'h000, inFill_reg, 12'h000}; // [R12]
        OFF_INT: rdata <= intView;
        OFF_RST: rdata <= rstView;
        OFF_PT_CFG: rdata <= ptCfg_reg;
        default: rdata <= 32'h00000000;                            // [R03]
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_fill_clear;
    @(posedge clock) disable iff (sys_rst)
      mbClear |=> (inFill_reg == 4'h0 && outFill_reg == 4'h0);
  endproperty
  a_fill_clear: assert property (p_fill_clear) else $error("fill clear failed"); // [R25]

  property p_in_set;
    @(posedge clock) disable iff (sys_rst) (host.inWriteBe[0] && !mbClear) |=> inFill_reg[0];
  endproperty
  a_in_set: assert property (p_in_set) else $error("incoming fill not set"); // [R13]

  property p_out_read_keeps;
    @(posedge clock) disable iff (sys_rst)
      (rd && bus.addr == OFF_MB_OUT && !wr && host.outReadBe == 4'h0 && !mbClear && !extMbWrite)
      |=> outFill_reg == $past(outFill_reg);
  endproperty
  a_out_read_keeps: assert property (p_out_read_keeps) else $error("out read changed"); // [R08]

  property p_any;
    @(posedge clock) disable iff (sys_rst) (rd && bus.addr == OFF_INT)
      |=> rdata[INT_ANY_BIT]
          == (rdata[INT_SELFTEST_BIT] || rdata[INT_OUT_BIT] || rdata[INT_IN_BIT]);
  endproperty
  a_any: assert property (p_any) else $error("bit 23 not OR"); // [R16]

  property p_selftest;
    @(posedge clock) disable iff (sys_rst)
      (host.selfTestStart || (intFlags_reg[2] && !(wr && bus.addr == OFF_INT && be[2]
       && bus.wdata[INT_SELFTEST_BIT]))) |=> intFlags_reg[2];
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test flag lost"); // [R17]

  property p_in_int;
    @(posedge clock) disable iff (sys_rst)
      (inEn_reg && host.inWriteBe[inSel_reg]) |=> intFlags_reg[0];
  endproperty
  a_in_int: assert property (p_in_int) else $error("incoming irq missing"); // [R20]

  property p_out_int;
    @(posedge clock) disable iff (sys_rst)
      (outEn_reg && host.outReadBe[outSel_reg]) |=> intFlags_reg[1];
  endproperty
  a_out_int: assert property (p_out_int) else $error("outgoing irq missing"); // [R19]

  property p_pt_inc;
    @(posedge clock) disable iff (sys_rst)
      (host.ptXferDone && !host.ptClaim) |=> ptAddr_reg == $past(ptAddr_reg) + 32'h00000004;
  endproperty
  a_pt_inc: assert property (p_pt_inc) else $error("pass-thru address not advanced"); // [R10]

  property p_nv_busy;
    @(posedge clock) disable iff (sys_rst) nvStart |-> nvState == NV_WAIT;
  endproperty
  a_nv_busy: assert property (p_nv_busy) else $error("nv not busy after start"); // [R28]

  c_mb_round: cover property (@(posedge clock)
    host.inWriteBe != 4'h0 ##[1:20] (rd && bus.addr == OFF_MB_IN));
  c_irq_clear: cover property (@(posedge clock) intPending ##[1:20] !intPending);
  c_nv: cover property (@(posedge clock) nvStart ##[1:50] nvDone);

endmodule

/* aor_registers_tb_top.sv */
`timescale 1ns/1ns
module aor_registers_tb_top
  import aor_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  aor_bus_s bus;
  aor_host_s host;
  aor_host_s hv;
  logic [31:0] rdata, mbOut, ptReadData, ptCfg, rv;
  logic [3:0] outFill, bistCode;
  logic [1:0] nvCmd;
  logic [7:0] nvWriteByte, nvReadByte, extMbData;
  logic extMbWrite, hostInEnable, hostOutEnable, hostInReadEvent, hostOutWriteEvent;
  logic ptWait, ptPassive, ptHostRead, rdFifoReset, intPending;
  logic nvStart, nvDone, nvFail, inEv, outEv, fifoEv;
  int numErrors = 0;
  int checked = 0;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  aor_registers aor_registers_inst (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .host(host), .extMbWrite(extMbWrite), .extMbData(extMbData), .hostInEnable(hostInEnable),
    .hostOutEnable(hostOutEnable), .hostInReadEvent(hostInReadEvent),
    .hostOutWriteEvent(hostOutWriteEvent), .mbOut(mbOut), .outFill(outFill),
    .ptReadData(ptReadData), .ptWait(ptWait), .ptPassive(ptPassive), .ptHostRead(ptHostRead),
    .rdFifoReset(rdFifoReset), .bistCode(bistCode), .intPending(intPending), .ptCfg(ptCfg),
    .nvStart(nvStart), .nvCmd(nvCmd), .nvWriteByte(nvWriteByte), .nvDone(nvDone),
    .nvFail(nvFail), .nvReadByte(nvReadByte));
  aor_nv_model aor_nv_model_inst (.clock(clock), .sys_rst(sys_rst), .nvStart(nvStart),
    .nvCmd(nvCmd), .nvWriteByte(nvWriteByte), .nvDone(nvDone), .nvFail(nvFail),
    .nvReadByte(nvReadByte));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One access per call; strobes held through the taking edge; mapped offsets only
  task automatic acc(input logic rd, input logic [6:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge clock);
    #1;
    bus.selectN = 1'b0;
    bus.rdN = !rd;
    bus.wrN = rd;
    bus.beN = ~be;
    bus.addr = a;
    bus.wdata = d;
    #10;
    inEv = hostInReadEvent;
    outEv = hostOutWriteEvent;
    fifoEv = rdFifoReset;
    @(posedge clock);
    #1;
    bus = '{selectN: 1'b1, rdN: 1'b1, wrN: 1'b1, beN: 4'hF, addr: 7'h00, wdata: 32'h00000000};
    rv = rdata;
  endtask
  task automatic hp();
    @(posedge clock);
    #1;
    host = hv;
    @(posedge clock);
    #1;
    host = '0;
    hv = '0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("fill", rv, 32'h00000000);
    acc(1, OFF_INT, 4'hF, 0);
    check("int", rv, 32'h00000C0C);
    acc(1, OFF_RST, 4'hF, 0);
    check("rstctl", rv, 32'h00000000);
    acc(1, OFF_PT_CFG, 4'hF, 0);
    check("ptcfg", rv, 32'h80808080);
    acc(0, OFF_PT_CFG, 4'h1, 32'h00000005);
    check("ptCfgOut", ptCfg, 32'h80808005);
    acc(0, OFF_MB_FILL, 4'hF, 32'hFFFFFFFF);
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("fillRo", rv, 32'h00000000);
  endtask
  task automatic t_inbox();
    hostInEnable = 1'b1;
    hv.inWriteBe = 4'hF;
    hv.inWriteData = 32'hA1B2C3D4;
    hp();
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("inFill", rv, 32'h0000F000);
    acc(1, OFF_MB_IN, 4'h1, 0);
    check("inByte0", {24'h000000, rv[7:0]}, 32'h000000D4);
    check("inReadEv", inEv, 1);
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("inFillRd", rv, 32'h0000E000);
    hostInEnable = 1'b0;
    acc(1, OFF_MB_IN, 4'hE, 0);
    check("inReadOff", inEv, 0);
    for (int k = 0; k < 4; k++)
    begin
      acc(0, OFF_INT, 4'hF, 32'h00000010 | k);
      hv.inWriteBe = 4'h1 << ((k + 1) % 4);
      hp();
      acc(1, OFF_INT, 4'hF, 0);
      check("inSelOther", rv, 32'h00000C1C | k);
      hv.inWriteBe = 4'h1 << k;
      hp();
      acc(0, OFF_INT, 4'hF, 32'h00000010 | k);
      acc(1, OFF_INT, 4'hF, 0);
      check("inSelHit", rv, 32'h00810C1C | k);
      check("pend", intPending, 1);
      acc(0, OFF_INT, 4'hF, 32'h00010010 | k);
      acc(1, OFF_INT, 4'hF, 0);
      check("inClr", rv, 32'h00000C1C | k);
    end
  endtask
  task automatic t_outbox();
    hostOutEnable = 1'b1;
    acc(0, OFF_MB_FILL, 4'hF, 32'h00000000);
    acc(0, OFF_RST, 4'hF, 32'h08000000);
    acc(0, OFF_MB_OUT, 4'h3, 32'h11223344);
    check("outWrEv", outEv, 1);
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("outFill", rv, 32'h30000000);
    @(posedge clock);
    #1;
    extMbData = 8'h5A;
    extMbWrite = 1'b1;
    @(posedge clock);
    #1;
    extMbWrite = 1'b0;
    acc(1, OFF_MB_OUT, 4'hF, 0);
    check("outMb", rv & 32'hFF00FFFF, 32'h5A003344);
    check("mbOutPort", mbOut & 32'hFF00FFFF, 32'h5A003344);
    check("outFillPort", outFill, 32'h0000000B);
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("outFillRd", rv, 32'hB0000000);
    acc(0, OFF_INT, 4'hF, 32'h00001100);
    hv.outReadBe = 4'h2;
    hp();
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("outFillHost", rv, 32'h90000000);
    acc(0, OFF_INT, 4'hF, 32'h00001100);
    acc(1, OFF_INT, 4'hF, 0);
    check("outInt", rv, 32'h00821D0C);
    acc(0, OFF_INT, 4'hF, 32'h00021100);
    acc(1, OFF_INT, 4'hF, 0);
    check("outClr", rv, 32'h00001D0C);
    acc(0, OFF_RST, 4'hF, 32'h08000000);
    acc(1, OFF_MB_FILL, 4'hF, 0);
    check("flagRst", rv, 32'h00000000);
  endtask
  task automatic t_selftest_rst();
    hv.selfTestStart = 1'b1;
    hp();
    acc(1, OFF_INT, 4'hF, 0);
    check("bist", {30'h0, rv[23], rv[20]}, 32'h00000003);
    acc(0, OFF_INT, 4'hF, 32'h00101100);
    acc(1, OFF_INT, 4'hF, 0);
    check("bistClr", {30'h0, rv[23], rv[20]}, 32'h00000000);
    acc(0, OFF_RST, 4'hF, 32'h0800A000);
    check("bistCode", bistCode, 32'h0000000A);
    acc(1, OFF_RST, 4'hF, 0);
    check("rstRead", rv, 32'h0000A000);
    acc(0, OFF_RST, 4'hF, 32'h02000000);
    check("fifoRst", fifoEv, 1);
  endtask
  task automatic t_passthru();
    ptPassive = 1'b1;
    ptHostRead = 1'b0;
    hv.ptClaim = 1'b1;
    hv.ptAddr = 32'h00001000;
    hv.ptWriteData = 32'hCAFEF00D;
    hp();
    check("waitW", ptWait, 1);
    acc(0, OFF_PT_ADDR, 4'hF, 32'hFFFFFFFF);
    acc(1, OFF_PT_ADDR, 4'hF, 0);
    check("ptAddr", rv, 32'h00001000);
    acc(1, OFF_PT_DATA, 4'hF, 0);
    check("ptData", rv, 32'hCAFEF00D);
    check("waitWEnd", ptWait, 0);
    hv.ptXferDone = 1'b1;
    hp();
    acc(1, OFF_PT_ADDR, 4'hF, 0);
    check("ptAddrInc", rv, 32'h00001004);
    ptHostRead = 1'b1;
    hv.ptClaim = 1'b1;
    hv.ptAddr = 32'h00002000;
    hp();
    check("waitR", ptWait, 1);
    acc(0, OFF_PT_DATA, 4'hF, 32'h55AA55AA);
    check("waitREnd", ptWait, 0);
    check("ptRdData", ptReadData, 32'h55AA55AA);
  endtask
  task automatic t_nvram();
    acc(0, OFF_RST, 4'hF, 32'h80120000);
    acc(0, OFF_RST, 4'hF, 32'hA0340000);
    check("nvPortLoad", nvWriteByte, 32'h00000034);
    acc(0, OFF_RST, 4'hF, 32'hE0000000);
    check("nvStartRd", nvStart, 1);
    acc(1, OFF_RST, 4'hF, 0);
    check("nvBusy", rv[31], 1);
    check("nvCmd", nvCmd, NV_READ);
    for (int i = 0; i < 60 && rv[31] !== 1'b0; i++)
      acc(1, OFF_RST, 4'hF, 0);
    check("nvReady", rv & 32'h90FF0000, 32'h006B0000);
    acc(0, OFF_RST, 4'hF, 32'hC0550000);
    check("nvWrStart", {nvStart, nvCmd, nvWriteByte}, {1'b1, NV_WRITE, 8'h55});
    acc(1, OFF_RST, 4'hF, 0);
    check("nvWrBusy", rv[31], 1);
    for (int j = 0; j < 60 && rv[31] !== 1'b0; j++)
      acc(1, OFF_RST, 4'hF, 0);
    check("nvWrDone", rv & 32'h90FF0000, 32'h00550000);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    forever #50 clock = ~clock;
  end
  initial
  begin
    bus = '{selectN: 1'b1, rdN: 1'b1, wrN: 1'b1, beN: 4'hF, addr: 7'h00, wdata: 32'h00000000};
    host = '0;
    hv = '0;
    extMbWrite = 1'b0;
    extMbData = 8'h00;
    hostInEnable = 1'b0;
    hostOutEnable = 1'b0;
    ptPassive = 1'b0;
    ptHostRead = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_inbox();
    t_outbox();
    t_selftest_rst();
    t_passthru();
    t_nvram();
    tally_and_finish();
  end
  // Whole run is a few hundred cycles; allow ample margin
  initial
  begin
    #2000000;
    numErrors++;
    tally_and_finish();
  end
endmodule
